// File: rtl/port_map_defs.svh
// Purpose: Constants for the switch port role map and configuration decode
// Assumes: Four ports, device number equals port number
// Notes:   Included by the package and the design module
`ifndef PORT_MAP_DEFS_SVH
`define PORT_MAP_DEFS_SVH
`define NUM_PORTS       3'd4
`define PORT_UP         5'h00
`define PORT_DN_A       5'h02
`define PORT_DN_B       5'h04
`define PORT_DN_C       5'h06
`define IDX_UP          2'h0
`define IDX_DN_A        2'h1
`define IDX_DN_B        2'h2
`define IDX_DN_C        2'h3
`define MAX_LANES       3'h4
`define SPEED_GEN1      2'h1
`define SPEED_GEN2      2'h2
`define SPEED_SUPPORTED 2'h3
`define ROLE_UPSTREAM   1'b0
`define ROLE_DOWNSTREAM 1'b1
`endif

// File: rtl/port_map_pkg.sv
// Purpose: Types for the switch port role map and configuration decode
// Assumes: Constants come from port_map_defs.svh
// Notes:   Request and answer travel as packed structs
`include "port_map_defs.svh"
package port_map_pkg;
  typedef enum logic [1:0] {
    ROUTE_NONE,
    ROUTE_BRIDGE,
    ROUTE_UR
  } route_type;
  typedef struct packed {
    logic       on_virtual_bus; // Set: target is the internal bus
    logic [4:0] dev_num;        // Target device number
    logic       is_write;       // Write when set
  } cfg_req_type;
  typedef struct packed {
    route_type  route;          // Where the request went
    logic [3:0] bridge_sel;     // One-hot bridge select
    logic       unsupported;    // Completed with UR status
  } cfg_ans_type;
  typedef struct packed {
    logic       role;           // Upstream or downstream
    logic [2:0] max_lanes;      // Widest link in lanes
    logic [1:0] speeds;         // Bit0 2.5 Gbps, bit1 5.0 Gbps
    logic [4:0] dev_num;        // Device number of its bridge
  } port_cfg_type;
endpackage

// File: rtl/switch_port_device_map.sv
// Purpose: Fixed port roles and configuration device decode for a four-port switch
// Assumes: Requests reach here already classified as type 0 or type 1 on the internal bus
// Notes:   Roles are hardwired; nothing here can be reconfigured by software
//          The answer is registered, one cycle after the request, so timing to the
//          completion logic does not depend on the compare depth
//          The write flag of a request is carried but not decoded: reads and writes route alike
// Overview of operation
// - Four ports numbered 0,2,4,6; port 0 is always the upstream port.
// - Ports 2,4,6 are downstream ports with a fixed role, except while reset holds their role at 0 (upstream).
// - Every port supports x4 links and both 2.5 and 5.0 Gbps rates.
// - Each port is its own virtual PCI-PCI bridge with its own config space.
// - Bridge device number equals port number; upstream bridge is device 0.
// - Config access to an absent virtual-bus device completes as Unsupported Request.
`timescale 1ns/1ps
`include "port_map_defs.svh"
module switch_port_device_map (
  input  wire logic                        core_clk_i,    // Core clock, 125 MHz
  input  wire logic                        resetn_i,      // Sync reset, active low
  input  wire logic                        req_valid_i,   // Config request present
  input  wire port_map_pkg::cfg_req_type   req_i,         // Config request fields
  output logic                             ans_valid_o,   // Answer valid, one cycle
  output port_map_pkg::cfg_ans_type        ans_o,         // Decode answer
  output port_map_pkg::port_cfg_type [3:0] port_cfg_o     // Per-port fixed setup
);
  import port_map_pkg::*;

  localparam logic [4:0] DEV_NUM [4] = '{`PORT_UP, `PORT_DN_A, `PORT_DN_B, `PORT_DN_C};

  logic        ans_valid_r;
  logic        ans_valid_nxt;
  cfg_ans_type ans_r;
  cfg_ans_type ans_nxt;
  port_cfg_type [3:0] port_cfg_r;
  port_cfg_type [3:0] port_cfg_nxt;
  logic [3:0]  hit;

  // Fixed per-port setup, built in one loop so the map cannot drift
  genvar g;
  generate
    for (g = 0; g < `NUM_PORTS; g = g + 1) begin : g_port
      // One bridge per port
      // Bridge g answers when its device number matches on the right bus
      assign hit[g] = (req_i.dev_num == DEV_NUM[g]) &&
                      (req_i.on_virtual_bus == (g != 0));
      always_comb begin
        port_cfg_nxt[g].role      = (g == 0) ? `ROLE_UPSTREAM : `ROLE_DOWNSTREAM;
        port_cfg_nxt[g].max_lanes = `MAX_LANES;
        port_cfg_nxt[g].speeds    = `SPEED_SUPPORTED;
        port_cfg_nxt[g].dev_num   = DEV_NUM[g];
      end

      // Per-port checks sit in the loop so every index is covered the same way
      // Width and rates on every port
      a_port_caps: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $past(resetn_i) |-> port_cfg_o[g].max_lanes == `MAX_LANES && port_cfg_o[g].speeds == `SPEED_SUPPORTED)
        else $error("Port link capability wrong");
      a_port_devnum: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $past(resetn_i) |-> port_cfg_o[g].dev_num == DEV_NUM[g])
        else $error("Port device number wrong");
      // Upstream only at index zero, downstream everywhere else
      a_port_role: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        $past(resetn_i) |-> port_cfg_o[g].role == ((g == 0) ? `ROLE_UPSTREAM : `ROLE_DOWNSTREAM))
        else $error("Port role wrong");
      // A request for this bridge selects this bridge and no other
      a_port_hit: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
        req_valid_i && req_i.dev_num == DEV_NUM[g] && req_i.on_virtual_bus == (g != 0)
        |=> ans_valid_o && ans_o.bridge_sel == (4'h1 << g))
        else $error("Bridge request misrouted");
    end
  endgenerate

  // Decode of a config request; one cycle of latency keeps the answer registered
  // Only one bridge can match, since every device number and bus pair is unique
  always_comb begin
    ans_valid_nxt       = req_valid_i;
    ans_nxt.route       = ROUTE_NONE;
    ans_nxt.bridge_sel  = 4'h0;
    ans_nxt.unsupported = 1'b0;
    if (req_valid_i) begin
      if (|hit) begin
        ans_nxt.route      = ROUTE_BRIDGE;
        ans_nxt.bridge_sel = hit;
      end else if (req_i.on_virtual_bus) begin
        // Absent device UR
        // Device 0 on the internal bus is absent too, so it lands here
        ans_nxt.route       = ROUTE_UR;
        ans_nxt.unsupported = 1'b1;
      end else begin
        // Other upstream-bus devices are not ours; leave routing to the link
        ans_nxt.route = ROUTE_NONE;
      end
    end
  end

  // Registers; reset clears the answer and the setup, which reloads its constants once reset is released
  // The setup resets to zero so a port never looks configured while the switch is held
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      ans_valid_r <= 1'b0;
      ans_r       <= '0;
      port_cfg_r  <= '0;
    end else begin
      ans_valid_r <= ans_valid_nxt;
      ans_r       <= ans_nxt;
      port_cfg_r  <= port_cfg_nxt;
    end
  end

  assign ans_valid_o = ans_valid_r;
  assign ans_o       = ans_r;
  assign port_cfg_o  = port_cfg_r;

  // Checks beside the logic
  sequence s_absent_req;
    req_valid_i && req_i.on_virtual_bus &&
    (req_i.dev_num != `PORT_DN_A) && (req_i.dev_num != `PORT_DN_B) && (req_i.dev_num != `PORT_DN_C);
  endsequence
  sequence s_ur_ans;
    ans_valid_o && ans_o.unsupported && (ans_o.bridge_sel == 4'h0);
  endsequence

  a_upstream_role: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $past(resetn_i) |-> port_cfg_o[0].role == `ROLE_UPSTREAM && port_cfg_o[0].dev_num == `PORT_UP)
    else $error("Port 0 not upstream");
  a_downstream_roles: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $past(resetn_i) |-> port_cfg_o[1].role && port_cfg_o[2].role && port_cfg_o[3].role)
    else $error("Downstream role lost");
  a_link_caps: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $past(resetn_i) |-> port_cfg_o[3].max_lanes == `MAX_LANES && port_cfg_o[2].speeds == `SPEED_SUPPORTED)
    else $error("Link capability wrong");
  a_one_bridge: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ans_valid_o |-> $onehot0(ans_o.bridge_sel))
    else $error("More than one bridge selected");
  a_dev_equals_port: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $past(resetn_i) |-> port_cfg_o[1].dev_num == `PORT_DN_A && port_cfg_o[3].dev_num == `PORT_DN_C)
    else $error("Device number differs from port");
  a_absent_ur: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    s_absent_req |=> s_ur_ans)
    else $error("Absent device not UR");
  a_route_dn_b: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i && req_i.on_virtual_bus && req_i.dev_num == `PORT_DN_B
    |=> ans_valid_o && ans_o.bridge_sel == 4'h4 && !ans_o.unsupported)
    else $error("Device 4 not routed");
  a_upstream_dev0: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i && !req_i.on_virtual_bus && req_i.dev_num == `PORT_UP |=> ans_o.bridge_sel == 4'h1)
    else $error("Upstream bridge not device 0");
  a_answer_pulse: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    !req_valid_i |=> !ans_valid_o && ans_o.route == ROUTE_NONE)
    else $error("Answer without request");

  // Further decode checks, all but a_single_hit written from the port constants rather than from the hit vector,
  // so a slip in the per-port compare shows here and not only in the bench
  // Limitation: the sideband path is not modelled in this block, so nothing here guards it

  // Device 2 on the internal bus reaches the first downstream bridge
  a_route_dn_a: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i && req_i.on_virtual_bus && req_i.dev_num == `PORT_DN_A
    |=> ans_valid_o && ans_o.bridge_sel == (4'h1 << `IDX_DN_A) && ans_o.route == ROUTE_BRIDGE)
    else $error("Device 2 not routed");

  // Device 6 on the internal bus reaches the last downstream bridge
  a_route_dn_c: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i && req_i.on_virtual_bus && req_i.dev_num == `PORT_DN_C
    |=> ans_valid_o && ans_o.bridge_sel == (4'h1 << `IDX_DN_C) && ans_o.route == ROUTE_BRIDGE)
    else $error("Device 6 not routed");

  // Device 0 seen on the internal bus is absent there, so it completes as UR
  a_internal_dev0: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i && req_i.on_virtual_bus && req_i.dev_num == `PORT_UP
    |=> ans_valid_o && ans_o.route == ROUTE_UR && ans_o.unsupported)
    else $error("Internal device 0 not UR");

  // Only device 0 is ours on the upstream bus; the rest is left to the link
  a_foreign_dev: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i && !req_i.on_virtual_bus && req_i.dev_num != `PORT_UP
    |=> ans_valid_o && ans_o.route == ROUTE_NONE && ans_o.bridge_sel == 4'h0 && !ans_o.unsupported)
    else $error("Foreign upstream device claimed");

  // A UR answer never also selects a bridge
  a_ur_exclusive: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ans_valid_o && ans_o.unsupported |-> ans_o.route == ROUTE_UR && ans_o.bridge_sel == 4'h0)
    else $error("UR answer selects a bridge");

  // A bridge answer is a plain route, never flagged unsupported
  a_bridge_clean: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ans_valid_o && (|ans_o.bridge_sel) |-> ans_o.route == ROUTE_BRIDGE && !ans_o.unsupported)
    else $error("Bridge answer flagged");

  // At most one bridge matches any request
  a_single_hit: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i |-> $onehot0(hit))
    else $error("Two bridges match one request");

  // The route code of an answer is always one of the three defined ones
  a_route_known: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ans_valid_o |-> ans_o.route inside {ROUTE_NONE, ROUTE_BRIDGE, ROUTE_UR})
    else $error("Undefined route code");

  // Every request gets its answer on the next edge; back to back requests are allowed
  a_answer_follows: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    req_valid_i |=> ans_valid_o)
    else $error("Request left unanswered");

  // An answer always has a request one edge before it
  a_answer_cause: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    ans_valid_o |-> $past(req_valid_i))
    else $error("Answer with no request");

  // Roles never change once loaded; two clean edges are needed because the
  // first edge after reset is the one that loads the setup
  a_setup_stable: assert property (@(posedge core_clk_i) disable iff (!resetn_i)
    $past(resetn_i) && $past(resetn_i, 2) |-> $stable(port_cfg_o))
    else $error("Port setup changed");

  // Reset clears every output on the edge after it is seen; not disabled by reset on purpose
  a_reset_clears: assert property (@(posedge core_clk_i)
    !resetn_i |=> !ans_valid_o && ans_o == '0 && port_cfg_o == '0)
    else $error("Outputs not cleared by reset");
endmodule

// File: test/cfg_requester.sv
// Purpose: Upstream requester model issuing config requests
// Assumes: go_i and fld_i settle before the rising edge
// Notes:   Idle fields toggle so a stale value never looks valid
`timescale 1ns/1ps
module cfg_requester (
  input  wire logic                      core_clk_i,  // Core clock
  input  wire logic                      go_i,        // Send a request
  input  wire port_map_pkg::cfg_req_type fld_i,       // Fields to send
  output logic                           req_valid_o, // Request strobe
  output port_map_pkg::cfg_req_type      req_o        // Request fields
);
  import port_map_pkg::*;
  initial req_valid_o = 1'b0;
  initial req_o = '0;
  // link traffic only
  // No sideband path exists here, so absent devices are never reached that way
  // Sample go_i and fld_i on the edge itself and drive 1 ns later; the bench changes them
  // at that same 1 ns mark, so reading them there would race
  always @(posedge core_clk_i) begin
    req_valid_o <= #1 go_i;
    req_o       <= #1 (go_i ? fld_i : ~req_o);
  end
endmodule

// File: test/switch_port_device_map_tb.sv
// Purpose: Self-checking bench for the port map and device decode
// Assumes: One answer a cycle after each request
// Notes:   Answer fields are only checked while the answer is valid
`timescale 1ns/1ps
module switch_port_device_map_tb;
  import port_map_pkg::*;
  logic               core_clk_i = 1'b0;
  logic               resetn_i = 1'b0;
  logic               go = 1'b0;
  logic               ans_valid_o;
  logic               req_valid;
  cfg_req_type        fld = '0;
  cfg_req_type        req;
  cfg_ans_type        ans_o;
  port_cfg_type [3:0] port_cfg_o;
  int                 mismatches = 0, tests_run = 0, cyc = 0, e_v, e_r, e_s, e_u, s;
  always #4 core_clk_i = ~core_clk_i;
  cfg_requester cfg_requester_i (.core_clk_i(core_clk_i), .go_i(go), .fld_i(fld), .req_valid_o(req_valid),
    .req_o(req));
  switch_port_device_map switch_port_device_map_i (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .req_valid_i(req_valid), .req_i(req), .ans_valid_o(ans_valid_o), .ans_o(ans_o), .port_cfg_o(port_cfg_o));
  task automatic complete_run;
    $display("Counts: %0d compares, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp_ans;
    tests_run++;
    if (ans_valid_o !== 1'(e_v) || (e_v != 0 && ans_o !== {2'(e_r), 4'(e_s), 1'(e_u)})) begin
      mismatches++;
      $display("[ERR] %0t answer wrong, want route %0d sel %0d", $time, e_r, e_s);
    end
  endtask
  task automatic cmp_cfg(input int i);
    tests_run++;
    if (port_cfg_o[i] !== {1'(i != 0), 3'h4, 2'h3, 5'(2 * i)}) begin
      mismatches++;
      $display("[ERR] %0t port %0d setup wrong", $time, i);
    end
  endtask
  // Reference decode, taken on the same edge as the design
  always @(posedge core_clk_i) begin
    cyc++;
    e_v = int'(resetn_i && req_valid);
    e_r = 0;
    e_s = 0;
    e_u = 0;
    if (e_v != 0 && req.on_virtual_bus) begin
      if (req.dev_num inside {2, 4, 6}) begin
        e_r = 1;
        e_s = 1 << (req.dev_num / 2);
      end else begin
        e_r = 2;
        e_u = 1;
      end
    end else if (e_v != 0 && req.dev_num == 0) begin
      e_r = 1;
      e_s = 1;
    end
    if (cyc == 3000) begin
      mismatches++;
      complete_run();
    end
  end
  // Sample away from the launching edge
  always @(negedge core_clk_i) if (resetn_i) cmp_ans();
  initial begin
    s = $urandom(36);
    repeat (4) @(posedge core_clk_i);
    #1 resetn_i = 1'b1;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    for (int i = 0; i < 4; i++) cmp_cfg(i);
    $display("Test port setup done");
    for (int i = 0; i < 64; i++) begin
      @(posedge core_clk_i);
      #1 go = 1'b1;
      fld = cfg_req_type'({i[5], i[4:0], i[0]});
    end
    $display("Test device sweep done");
    for (int i = 0; i < 300; i++) begin
      @(posedge core_clk_i);
      #1 go = 1'($urandom % 2);
      fld = cfg_req_type'(7'($urandom));
      resetn_i = (i < 150 || i > 152);
    end
    @(posedge core_clk_i);
    #1 go = 1'b0;
    repeat (4) @(posedge core_clk_i);
    @(negedge core_clk_i);
    for (int i = 0; i < 4; i++) cmp_cfg(i);
    $display("Test random traffic done");
    complete_run();
  end
endmodule
